/* File: core/wim_pkg.sv */
// Constants, register map and types for the wake input monitor.
// Assumes a single 125 MHz clock and a 32-bit AHB-Lite register bus.
package wim_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_WAKE_EN = 8'h00;
  localparam logic [7:0] OFS_PULL = 8'h04;
  localparam logic [7:0] OFS_FILTER = 8'h08;
  localparam logic [7:0] OFS_TIMER_A = 8'h0c;
  localparam logic [7:0] OFS_TIMER_B = 8'h10;
  localparam logic [7:0] OFS_WAKE_SRC = 8'h14;
  localparam logic [7:0] OFS_ALT_SRC = 8'h18;
  localparam logic [7:0] OFS_LEVEL = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_MODE = 8'h24;
  localparam logic [7:0] OFS_HS_CTRL = 8'h28;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TMR_PERIOD_LSB = 0;
  localparam int TMR_ON_LSB = 16;
  localparam logic [31:0] RST_TIMER = 32'h0000_0000;
  localparam logic [4:0] RST_WAKE_EN = 5'h00;
  localparam logic [5:0] RST_PULL = 6'h00;
  localparam logic [5:0] RST_FILTER = 6'h00;
  localparam logic [4:0] RST_IRQ_MASK = 5'h00;
  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_FAILSAFE = 2'h3;
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic [1:0] PULL_AUTO = 2'h3;
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
  localparam logic [2:0] HS_OFF = 3'h0;
  localparam logic [2:0] HS_TIMER_A = 3'h1;
  localparam logic [2:0] HS_TIMER_B = 3'h2;
  // ----------------------------------------------------------------
  // Timing: 1 us tick from the 8 ns clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK_PERIOD_NS = 1;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = (TICK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
  localparam int FLT_SHORT_US = 16;
  localparam int FLT_LONG_US = 64;
  localparam logic [6:0] FLT_SHORT_TICKS = 7'(FLT_SHORT_US / TICK_US);
  localparam logic [6:0] FLT_LONG_TICKS = 7'(FLT_LONG_US / TICK_US);
  // Filter state machine
  typedef enum logic [1:0] {
    WIM_FLT_STABLE = 2'b01,
    WIM_FLT_QUAL = 2'b10
  } wim_flt_state_e;
endpackage : wim_pkg

/* File: core/wim_flt_if.sv */
// Link between the monitor top and one input filter.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface wim_flt_if;
  logic pin_in;
  logic sample_en;
  logic tick;
  logic long_flt;
  logic evt;
  logic level;
  modport ctl (output pin_in, output sample_en, output tick, output long_flt, input evt, input level);
  modport flt (input pin_in, input sample_en, input tick, input long_flt, output evt, output level);
endinterface : wim_flt_if

/* File: core/wim_filter.sv */
// Edge qualification filter for one synchronised wake input.
// Assumes pin_in is already synchronised and tick is a 1 us pulse.
`timescale 1ns/1ps
module wim_filter
  import wim_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Filter link
  wim_flt_if.flt fi
);
  wim_flt_state_e state;
  wim_flt_state_e next_state;
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic level;
  logic next_level;
  logic evt;
  logic next_evt;
  logic [6:0] lim;

  // ----------------------------------------------------------------
  // Qualification
  // ----------------------------------------------------------------
  // Leaving the sample window drops a half-qualified edge; the on-time must cover the filter
  always_comb
  begin
    lim = fi.long_flt ? FLT_LONG_TICKS : FLT_SHORT_TICKS;
    next_state = state;
    next_cnt = cnt;
    next_level = level;
    next_evt = 1'b0;
    if (!fi.sample_en)
    begin
      next_state = WIM_FLT_STABLE;
      next_cnt = 7'h00;
    end
    else
    begin
      case (state)
        WIM_FLT_STABLE:
        begin
          if (fi.pin_in != level)
          begin
            next_state = WIM_FLT_QUAL;
            next_cnt = 7'h00;
          end
        end
        WIM_FLT_QUAL:
        begin
          if (fi.pin_in == level)
            next_state = WIM_FLT_STABLE;
          else if (fi.tick)
          begin
            if (cnt == lim - 7'h01)
            begin
              next_level = fi.pin_in;
              next_evt = 1'b1;
              next_state = WIM_FLT_STABLE;
            end
            else
              next_cnt = cnt + 7'h01;
          end
        end
        default:
        begin
          next_state = WIM_FLT_STABLE;
          next_cnt = 7'h00;
        end
      endcase
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= WIM_FLT_STABLE;
      cnt <= 7'h00;
      level <= 1'b0;
      evt <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      level <= next_level;
      evt <= next_evt;
    end
  end

  assign fi.evt = evt;
  assign fi.level = level;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Cycles for which the input has differed from the accepted level
  logic [15:0] run_cnt;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      run_cnt <= 16'h0000;
    else if (fi.pin_in == level || !fi.sample_en)
      run_cnt <= 16'h0000;
    else if (run_cnt != 16'hffff)
      run_cnt <= run_cnt + 16'h0001;
  end

  AST_FLT_MIN_TIME: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(evt) |-> $past(run_cnt) >= 16'(int'(FLT_SHORT_TICKS - 7'h01) * TICK_CYCLES))
    else $error("edge accepted before the filter time");
  AST_FLT_LEVEL_FLIP: assert property (@(posedge hclk) disable iff (!hresetn)
    evt |-> level != $past(level))
    else $error("event without level change");
  AST_FLT_WINDOW: assert property (@(posedge hclk) disable iff (!hresetn)
    !fi.sample_en |=> !evt && $stable(level))
    else $error("input evaluated outside the sample window");
  COV_FLT_REJECT: cover property (@(posedge hclk) disable iff (!hresetn)
    state == WIM_FLT_QUAL ##1 state == WIM_FLT_STABLE && !evt);
endmodule : wim_filter

/* File: core/wim_top.sv */
// Wake input monitor: three wake pins, two alternate failure-output pins, AHB-Lite registers.
// Assumes pins are asynchronous to hclk and a single AHB-Lite master drives the bus.
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
module wim_top
  import wim_pkg::*;
#(
  parameter int NUM_WAKE = 3,
  parameter int NUM_ALT = 2
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sensed pins
  input wire logic [NUM_WAKE-1:0] wake_pin,
  input wire logic [NUM_ALT-1:0] failure_output_pins,
  // Pull current sources
  output logic [NUM_WAKE-1:0] pull_up_en,
  output logic [NUM_WAKE-1:0] pull_dn_en,
  // Cyclic sense supply and wake signalling
  output logic high_side_output_1,
  output logic irq,
  output logic wake_req
);
  localparam int NPIN = NUM_WAKE + NUM_ALT;

  // ----------------------------------------------------------------
  // Pin synchronisers and 1 us tick
  // ----------------------------------------------------------------
  logic [NPIN-1:0] sync_a;
  logic [NPIN-1:0] sync_b;
  logic [6:0] div;
  logic [6:0] next_div;
  logic tick;
  logic next_tick;

  // Second stage is the only reader of the first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {failure_output_pins, wake_pin};
      sync_b <= sync_a;
    end
  end

  // Divider: the filter interval is counted in these 1 us ticks
  always_comb
  begin
    next_tick = (div == TICK_LAST);
    next_div = next_tick ? 7'h00 : div + 7'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div <= 7'h00;
      tick <= 1'b0;
    end
    else
    begin
      div <= next_div;
      tick <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [NPIN-1:0] wake_enable_control;
  logic [2*NUM_WAKE-1:0] pull_current_control;
  logic [2*NUM_WAKE-1:0] filter_sense_control;
  logic [31:0] timer_ctrl [2];
  logic [NUM_WAKE-1:0] wake_source_status;
  logic [NUM_ALT-1:0] alt_pin_wake_status;
  logic [NUM_WAKE-1:0] pin_level_status;
  logic [NPIN-1:0] irq_mask;
  logic [1:0] mode_control;
  logic [2:0] hs_output_control;

  // ----------------------------------------------------------------
  // Cyclic sense timers
  // ----------------------------------------------------------------
  logic [15:0] tmr_cnt [2];
  logic [1:0] win;

  for (genvar t = 0; t < 2; t++)
  begin : g_tmr
    logic [15:0] period;
    logic [15:0] on_time;
    logic [15:0] next_cnt;
    assign period = timer_ctrl[t][TMR_PERIOD_LSB +: 16];
    assign on_time = timer_ctrl[t][TMR_ON_LSB +: 16];
    assign win[t] = (tmr_cnt[t] < on_time);
    // Wrap at the period; a zero period keeps the window fixed
    always_comb
    begin
      next_cnt = tmr_cnt[t];
      if (tick)
        next_cnt = (tmr_cnt[t] + 16'h0001 >= period) ? 16'h0000 : tmr_cnt[t] + 16'h0001;
    end
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        tmr_cnt[t] <= 16'h0000;
      else
        tmr_cnt[t] <= next_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Input filters
  // ----------------------------------------------------------------
  wim_flt_if fl [NPIN] ();
  logic [NPIN-1:0] evt;
  logic [NPIN-1:0] lvl;

  for (genvar g = 0; g < NPIN; g++)
  begin : g_pin
    if (g < NUM_WAKE)
    begin : g_wake
      logic [1:0] fsel;
      assign fsel = filter_sense_control[2*g +: 2];
      assign fl[g].sample_en = fsel[1] ? win[fsel[0]] : 1'b1;
      assign fl[g].long_flt = (fsel == FLT_STATIC_LONG);
    end
    else
    begin : g_alt
      assign fl[g].sample_en = 1'b1;
      assign fl[g].long_flt = 1'b0;
    end
    assign fl[g].pin_in = sync_b[g];
    assign fl[g].tick = tick;
    assign evt[g] = fl[g].evt;
    assign lvl[g] = fl[g].level;
    wim_filter u_flt (
      .hclk(hclk),
      .hresetn(hresetn),
      .fi(fl[g])
    );
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait states, read data registered in address phase
  // ----------------------------------------------------------------
  logic wr_pend;
  logic [7:0] wr_addr;
  logic next_wr_pend;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic addr_ok;
  logic [31:0] rmux;

  assign addr_ok = hsel && hready && htrans[1];

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    case (haddr[7:0])
      OFS_WAKE_EN: rmux = 32'(wake_enable_control);
      OFS_PULL: rmux = 32'(pull_current_control);
      OFS_FILTER: rmux = 32'(filter_sense_control);
      OFS_TIMER_A: rmux = timer_ctrl[0];
      OFS_TIMER_B: rmux = timer_ctrl[1];
      OFS_WAKE_SRC: rmux = 32'(wake_source_status);
      OFS_ALT_SRC: rmux = 32'(alt_pin_wake_status);
      OFS_LEVEL: rmux = 32'(pin_level_status);
      OFS_IRQ_MASK: rmux = 32'(irq_mask);
      OFS_MODE: rmux = 32'(mode_control);
      OFS_HS_CTRL: rmux = 32'(hs_output_control);
      default: rmux = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000)
      rmux = 32'h0000_0000;
    next_wr_pend = addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
    next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
    next_hrdata = (addr_ok && !hwrite) ? rmux : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register update, flags, pulls, interrupt and wake
  // ----------------------------------------------------------------
  logic [NPIN-1:0] next_wake_en;
  logic [2*NUM_WAKE-1:0] next_pull;
  logic [2*NUM_WAKE-1:0] next_filter;
  logic [31:0] next_timer [2];
  logic [NUM_WAKE-1:0] next_wake_src;
  logic [NUM_ALT-1:0] next_alt_src;
  logic [NUM_WAKE-1:0] next_level;
  logic [NPIN-1:0] next_mask;
  logic [1:0] next_mode;
  logic [2:0] next_hs;
  logic [NUM_WAKE-1:0] next_pu;
  logic [NUM_WAKE-1:0] next_pd;
  logic next_hs1;
  logic next_irq;
  logic next_wake_req;
  logic [NPIN-1:0] hit;
  logic awake;

  always_comb
  begin
    next_wake_en = wake_enable_control;
    next_pull = pull_current_control;
    next_filter = filter_sense_control;
    next_timer = timer_ctrl;
    next_mask = irq_mask;
    next_mode = mode_control;
    next_hs = hs_output_control;
    next_wake_src = wake_source_status;
    next_alt_src = alt_pin_wake_status;
    if (wr_pend)
    begin
      case (wr_addr)
        OFS_WAKE_EN: next_wake_en = hwdata[NPIN-1:0];
        OFS_PULL: next_pull = hwdata[2*NUM_WAKE-1:0];
        OFS_FILTER: next_filter = hwdata[2*NUM_WAKE-1:0];
        OFS_TIMER_A: next_timer[0] = hwdata;
        OFS_TIMER_B: next_timer[1] = hwdata;
        OFS_WAKE_SRC: next_wake_src = wake_source_status & ~hwdata[NUM_WAKE-1:0];
        OFS_ALT_SRC: next_alt_src = alt_pin_wake_status & ~hwdata[NUM_ALT-1:0];
        OFS_IRQ_MASK: next_mask = hwdata[NPIN-1:0];
        OFS_MODE: next_mode = hwdata[1:0];
        OFS_HS_CTRL: next_hs = hwdata[2:0];
        default: next_hs = hs_output_control;
      endcase
    end
    // Only enabled pins can flag; a new event beats a same-cycle clear
    hit = evt & wake_enable_control;
    next_wake_src = next_wake_src | hit[NUM_WAKE-1:0];
    next_alt_src = next_alt_src | hit[NPIN-1:NUM_WAKE];
    awake = (mode_control == MODE_ACTIVE) || (mode_control == MODE_STOP);
    // Level view frozen outside active and stop, where bus reads return the last level taken while awake
    next_level = awake ? lvl[NUM_WAKE-1:0] : pin_level_status;
    for (int i = 0; i < NUM_WAKE; i++)
    begin
      case (pull_current_control[2*i +: 2])
        PULL_DOWN:
        begin
          next_pu[i] = 1'b0;
          next_pd[i] = 1'b1;
        end
        PULL_UP:
        begin
          next_pu[i] = 1'b1;
          next_pd[i] = 1'b0;
        end
        PULL_AUTO:
        begin
          next_pu[i] = lvl[i];
          next_pd[i] = !lvl[i];
        end
        default:
        begin
          next_pu[i] = 1'b0;
          next_pd[i] = 1'b0;
        end
      endcase
    end
    case (hs_output_control)
      HS_TIMER_A: next_hs1 = win[0];
      HS_TIMER_B: next_hs1 = win[1];
      default: next_hs1 = 1'b0;
    endcase
    next_irq = awake && |({alt_pin_wake_status, wake_source_status} & irq_mask);
    next_wake_req = !awake && |hit;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_enable_control <= RST_WAKE_EN;
      pull_current_control <= RST_PULL;
      filter_sense_control <= RST_FILTER;
      timer_ctrl[0] <= RST_TIMER;
      timer_ctrl[1] <= RST_TIMER;
      irq_mask <= RST_IRQ_MASK;
      mode_control <= MODE_ACTIVE;
      hs_output_control <= HS_OFF;
      wake_source_status <= '0;
      alt_pin_wake_status <= '0;
      pin_level_status <= '0;
      pull_up_en <= '0;
      pull_dn_en <= '0;
      high_side_output_1 <= 1'b0;
      irq <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      wake_enable_control <= next_wake_en;
      pull_current_control <= next_pull;
      filter_sense_control <= next_filter;
      timer_ctrl <= next_timer;
      irq_mask <= next_mask;
      mode_control <= next_mode;
      hs_output_control <= next_hs;
      wake_source_status <= next_wake_src;
      alt_pin_wake_status <= next_alt_src;
      pin_level_status <= next_level;
      pull_up_en <= next_pu;
      pull_dn_en <= next_pd;
      high_side_output_1 <= next_hs1;
      irq <= next_irq;
      wake_req <= next_wake_req;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt[0] && wake_enable_control[0]) |=> wake_source_status[0])
    else $error("wake flag lost");
  AST_NO_FLAG_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(wake_source_status[0]) |-> $past(wake_enable_control[0]) && $past(evt[0]))
    else $error("flag set without enabled event");
  AST_ALT_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt[NUM_WAKE] && wake_enable_control[NUM_WAKE]) |=> alt_pin_wake_status[0])
    else $error("alternate pin event not flagged");
  AST_IRQ_ACTIVE: assert property (@(posedge hclk) disable iff (!hresetn)
    (awake && (wake_source_status[2] && irq_mask[2])) |=> irq)
    else $error("interrupt missing in active or stop");
  AST_IRQ_SLEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    !awake |=> !irq)
    else $error("interrupt raised in sleep or fail-safe");
  AST_WAKE_SLEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    (!awake && |hit) |=> wake_req ##1 (wake_req == (!$past(awake) && |$past(hit))))
    else $error("wake request wrong");
  AST_AUTO_PULL: assert property (@(posedge hclk) disable iff (!hresetn)
    (pull_current_control[1:0] == PULL_AUTO) ##1 (pull_current_control[1:0] == PULL_AUTO)
      |-> pull_up_en[0] == $past(lvl[0]) && pull_dn_en[0] == !$past(lvl[0]))
    else $error("automatic pull not following level");
  AST_HS_TIMER_B: assert property (@(posedge hclk) disable iff (!hresetn)
    (hs_output_control == HS_TIMER_B) |=> high_side_output_1 == $past(win[1]))
    else $error("high-side output not following timer B");
  AST_LEVEL_LIVE: assert property (@(posedge hclk) disable iff (!hresetn)
    awake |=> pin_level_status == $past(lvl[NUM_WAKE-1:0]))
    else $error("level register stale in active or stop");
  COV_WAKE_FROM_SLEEP: cover property (@(posedge hclk) disable iff (!hresetn) $rose(wake_req));
  COV_IRQ: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  COV_CYCLIC_EVT: cover property (@(posedge hclk) disable iff (!hresetn)
    filter_sense_control[5] && evt[2]);
endmodule : wim_top

/* File: sim/wim_pins_model.sv */
// Switch contacts on the wake pins and the failure-output pins.
// Assumes the bench calls its tasks from the hclk domain.
`timescale 1ns/1ps
module wim_pins_model
(
  // Clock
  input wire logic hclk,
  // Contacts
  output logic [2:0] wake_pin,
  output logic [1:0] failure_output_pins
);
  // ----------------------------------------
  // Contact motion
  // ----------------------------------------
  // All contacts open at power-up
  initial {failure_output_pins, wake_pin} = 5'h00;
  // Contacts move just after an edge, never mid-cycle
  task automatic set(input logic [4:0] v);
    @(posedge hclk);
    {failure_output_pins, wake_pin} <= v;
  endtask : set
  // Bounce of n cycles on pin i, then back to rest
  task automatic bounce(input int i, input int n);
    @(posedge hclk);
    wake_pin <= wake_pin ^ (3'h1 << i);
    repeat (n) @(posedge hclk);
    wake_pin <= wake_pin ^ (3'h1 << i);
  endtask : bounce
endmodule : wim_pins_model

/* File: sim/wake_input_monitor_tb.sv */
// Self-checking bench for the wake input monitor.
// Assumes the design files and the contact model compile first.
`timescale 1ns/1ps
module wake_input_monitor_tb
  import wim_pkg::*;
;
  // ----------------------------------------
  // Signals, instances, helpers
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, r;
  logic hreadyout, hresp, irq, wake_req, hs1;
  logic [2:0] wake_pin, pu, pd;
  logic [1:0] fo;
  logic [31:0] seed = 32'h19;
  int err_total = 0;
  int compares = 0;
  int wakes = 0;
  int hs_on = 0;
  // Waits cover sync plus a 16 us or a 64 us filter
  localparam int WS = 2200;
  localparam int WL = 8200;
  localparam logic [7:0] ZOFS [6] = '{OFS_WAKE_EN, OFS_PULL, OFS_FILTER, OFS_WAKE_SRC, OFS_IRQ_MASK, 8'h3c};
  wim_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .wake_pin(wake_pin), .failure_output_pins(fo), .pull_up_en(pu), .pull_dn_en(pd),
    .high_side_output_1(hs1), .irq(irq), .wake_req(wake_req));
  wim_pins_model sw (.hclk(hclk), .wake_pin(wake_pin), .failure_output_pins(fo));
  // 125 MHz clock
  initial
  begin
    forever #4 hclk = ~hclk;
  end
  // Wake request stands one cycle, so count it at every edge
  always @(posedge hclk)
    if (wake_req === 1'b1)
      wakes <= wakes + 1;
  // High-side on-cycles are summed here; the sequence takes differences over one period
  always @(posedge hclk)
    if (hs1 === 1'b1)
      hs_on <= hs_on + 1;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Expected {up, down} for a pull code and an accepted level
  function automatic logic [31:0] pull_exp(input logic [1:0] c, input logic lvl);
    return (c == PULL_AUTO) ? {30'h0, lvl, ~lvl} : {30'h0, c == PULL_UP, c == PULL_DOWN};
  endfunction : pull_exp
  // One single AHB-Lite transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdchk
  task automatic pause(input int n);
    repeat (n) @(posedge hclk);
  endtask : pause
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // Main sequence
  initial
  begin
    pause(20);
    hresetn <= 1'b1;
    // Reset values, then an unmapped word that reads zero
    foreach (ZOFS[i]) rdchk(ZOFS[i], 32'h0);
    // Random field values; unused upper bits read zero
    repeat (4)
    begin
      r = xs();
      bus(1'b1, OFS_PULL, r);
      rdchk(OFS_PULL, r & 32'h3f);
      bus(1'b1, OFS_FILTER, ~r);
      rdchk(OFS_FILTER, ~r & 32'h3f);
    end
    bus(1'b1, OFS_FILTER, 32'h0);
    // Every pull code on pin 0 while its level is low
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, OFS_PULL, 32'(c));
      pause(3);
      chk({30'h0, pu[0], pd[0]}, pull_exp(2'(c), 1'b0));
    end
    bus(1'b1, OFS_WAKE_EN, 32'h1);
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    bus(1'b1, OFS_MODE, {30'h0, MODE_ACTIVE});
    // A bounce shorter than the filter is dropped
    sw.bounce(0, 1000);
    pause(WS);
    rdchk(OFS_WAKE_SRC, 32'h0);
    // Held rise: flag, interrupt, level, automatic pull-up
    sw.set(5'h01);
    pause(WS);
    rdchk(OFS_WAKE_SRC, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdchk(OFS_LEVEL, 32'h1);
    chk({30'h0, pu[0], pd[0]}, pull_exp(PULL_AUTO, 1'b1));
    bus(1'b1, OFS_WAKE_SRC, 32'h1);
    pause(2);
    rdchk(OFS_WAKE_SRC, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Disabled pin 1 still reports its level
    sw.set(5'h03);
    pause(WS);
    rdchk(OFS_WAKE_SRC, 32'h0);
    rdchk(OFS_LEVEL, 32'h3);
    // Long filter drops a 40 us bounce but keeps a held fall
    bus(1'b1, OFS_FILTER, {30'h0, FLT_STATIC_LONG});
    sw.bounce(0, 5000);
    pause(WL);
    rdchk(OFS_WAKE_SRC, 32'h0);
    sw.set(5'h02);
    pause(WL);
    rdchk(OFS_WAKE_SRC, 32'h1);
    bus(1'b1, OFS_WAKE_SRC, 32'h1);
    // Sleep: an event pulses the wake request once, no interrupt
    bus(1'b1, OFS_FILTER, {30'h0, FLT_STATIC_SHORT});
    bus(1'b1, OFS_WAKE_EN, 32'h9);
    bus(1'b1, OFS_MODE, {30'h0, MODE_SLEEP});
    sw.set(5'h03);
    pause(WS);
    chk(32'(wakes), 32'h1);
    chk({31'h0, irq}, 32'h0);
    // Alternate pin event lands in its own status word
    sw.set(5'h0b);
    pause(WS);
    rdchk(OFS_ALT_SRC, 32'h1);
    // Cyclic sensing of pin 2 on timer B: high-side duty over one period, then a held rise
    bus(1'b1, OFS_MODE, {30'h0, MODE_ACTIVE});
    bus(1'b1, OFS_WAKE_SRC, 32'h7);
    bus(1'b1, OFS_IRQ_MASK, 32'h4);
    bus(1'b1, OFS_WAKE_EN, 32'h4);
    bus(1'b1, OFS_FILTER, 32'h30);
    bus(1'b1, OFS_TIMER_B, 32'h0014_0028);
    bus(1'b1, OFS_HS_CTRL, {29'h0, HS_TIMER_B});
    pause(2);
    r = 32'(hs_on);
    pause(40 * TICK_CYCLES);
    chk(32'(hs_on) - r, 32'(20 * TICK_CYCLES));
    sw.set(5'h0f);
    pause(7200);
    rdchk(OFS_WAKE_SRC, 32'h4);
    chk({31'h0, irq}, 32'h1);
    rdchk(OFS_LEVEL, 32'h7);
    close_out();
  end
  // Watchdog well past the ~46k cycles the sequence needs
  initial
  begin
    #600000;
    err_total++;
    close_out();
  end
endmodule : wake_input_monitor_tb
